// ### logic/bsc_pkg.sv
`default_nettype none

// ****************************************************************
// Shared constants for the audio control register group
// ****************************************************************
package bsc_pkg;

    // Control-bus subaddress and register addresses
    localparam logic [7:0]  SUBADDR_AUDIO_WR    = 8'h12;
    localparam logic [15:0] REG_LINE_OUT1_VOL   = 16'h0007;
    localparam logic [15:0] REG_SWITCH_PINS     = 16'h0013;
    localparam logic [15:0] REG_BEEP_TONE       = 16'h0014;
    localparam logic [15:0] REG_LINE_OUT2_VOL   = 16'h0040;
    localparam logic [15:0] REG_BASS_CEILING    = 16'h0069;
    localparam logic [15:0] REG_BASS_HARMONIC   = 16'h006A;
    localparam logic [15:0] REG_BASS_UPPER_CORN = 16'h006B;
    localparam logic [15:0] REG_BASS_LOWER_CORN = 16'h006C;

    // Field positions
    localparam int unsigned HI_MSB    = 15;
    localparam int unsigned HI_LSB    = 8;
    localparam int unsigned FINE_MSB  = 7;
    localparam int unsigned FINE_LSB  = 5;
    localparam int unsigned PIN1_BIT  = 15;
    localparam int unsigned PIN0_BIT  = 14;
    localparam int unsigned SW_MSB    = 13;
    localparam int unsigned SW_LSB    = 5;
    localparam int unsigned LO_MSB    = 7;
    localparam int unsigned LO_LSB    = 0;

    // Ceiling, harmonic and beep volume limits
    localparam logic signed [7:0] CEIL_MIN_DBFS = 8'shE0;
    localparam logic signed [7:0] CEIL_MAX_DBFS = 8'sh00;
    localparam logic [7:0]        HARM_MAX      = 8'h7F;
    localparam logic [7:0]        BEEP_VOL_MAX  = 8'h7F;

    // Corner frequency codes, 10 Hz per step
    localparam logic [7:0] UPPER_CODE_MIN = 8'h05;
    localparam logic [7:0] LOWER_CODE_MIN = 8'h03;
    localparam logic [7:0] CORNER_CODE_MAX = 8'h1E;
    localparam logic [8:0] HZ_PER_STEP    = 9'h00A;

    // Line-output volume codes
    localparam logic [7:0]        VOL_MUTE_CODE = 8'h00;
    localparam logic signed [8:0] VOL_ZERO_DB   = 9'sh073;

    // Reset values of the decoded fields
    localparam logic signed [11:0] LINE_GAIN_RST  = 12'sh000;
    localparam logic [8:0]         UPPER_HZ_RST   = 9'h032;
    localparam logic [8:0]         LOWER_HZ_RST   = 9'h01E;

    // Limiter: largest gain cut in dB
    localparam logic [5:0] LIM_CUT_MAX = 6'h20;

    // Source choices of the analog switch matrix
    typedef enum logic [2:0] {
        SRC_IN1  = 3'b000,
        SRC_IN2  = 3'b001,
        SRC_IN3  = 3'b010,
        SRC_IN4  = 3'b011,
        SRC_MONO = 3'b100,
        SRC_DAC1 = 3'b101,
        SRC_DAC2 = 3'b110,
        SRC_MUTE = 3'b111
    } bsc_src_type;

endpackage

`default_nettype wire

// ### logic/bsc_field_reg.sv
`default_nettype none

// ****************************************************************
// One decoded control field, loaded whole in a single edge
// ****************************************************************
module bsc_field_reg #(
    parameter int unsigned            WIDTH     = 8,
    parameter logic [WIDTH-1:0]       RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    // Load strobe and decoded value
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_data,
    // Held field
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] field_d;
    logic [WIDTH-1:0] field_q;

    // Whole field replaced at once, never piecewise
    always_comb begin
        field_d = i_load ? i_data : field_q;
    end

    // Field storage
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            field_q <= RESET_VAL;
        end else begin
            field_q <= field_d;
        end
    end

    assign o_q = field_q;

endmodule // bsc_field_reg

`default_nettype wire

// ### logic/bsc_ctrl_regs.sv
// Summary of operation
// - Register writes on subaddress 0x12 carry a register address and 16-bit word.
// - Ceiling bits 15:8 give 1 dBFS steps, 0x00 is 0, down to 0xE0 -32.
// - Enhancer gain is lowered automatically while its output exceeds the ceiling.
// - Harmonic ratio bits 15:8: 0x00 none, 0x3F half, 0x7F harmonics only.
// - Harmonics are generated only below the programmed lower corner.
// - Upper corner code 5 to 30 in 10 Hz units, 50 to 300 Hz.
// - Lower corner code 3 to 30 in 10 Hz units, 30 to 300 Hz.
// - Line volume bits 15:8 in 1 dB steps, 0x73 is 0 dB, 0x00 mutes.
// - Line volume bits 7:5 add 0.125 dB per step on top.
// - Switch bits 15 and 14 drive pins 1 and 0 while mode bit 3 is low.
// - DSP input selector decodes pattern xxxxABxxC of bits 13:5.
// - Line output 1 selector decodes pattern xxABxxxCx of bits 13:5.
// - Line output 2 selector decodes pattern ABxxxxCxx of bits 13:5.
// - Reset switch positions apply at first write, or that write replaces them.
// - Beep volume bits 15:8 (0 off, 0x7F max), frequency bits 7:0.
`default_nettype none

module bsc_ctrl_regs #(
    parameter int unsigned RELEASE_DIV = 64
) (
    // Clock and reset
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    // Decoded control-bus write
    input  wire logic              i_wr_stb,
    input  wire logic [7:0]        i_wr_subaddr,
    input  wire logic [15:0]       i_wr_regaddr,
    input  wire logic [15:0]       i_wr_data,
    // Operating mode and enhancer level feedback
    input  wire logic              i_mode_bit3,
    input  wire logic              i_clip_dynamic,
    input  wire logic              i_bass_level_stb,
    input  wire logic signed [7:0] i_bass_level_dbfs,
    // Bass enhancer settings
    output logic signed [7:0]      o_bass_ceiling_dbfs,
    output logic [5:0]             o_bass_gain_cut_db,
    output logic [6:0]             o_bass_harmonic_ratio,
    output logic [8:0]             o_bass_upper_corner_hz,
    output logic [8:0]             o_bass_lower_corner_hz,
    // Line output volumes, eighth-dB units
    output logic signed [11:0]     o_line1_gain,
    output logic                   o_line1_mute,
    output logic signed [11:0]     o_line2_gain,
    output logic                   o_line2_mute,
    // Switch matrix and digital pins
    output logic                   o_switch_active,
    output logic [2:0]             o_dsp_in_sel,
    output logic [2:0]             o_line1_sel,
    output logic [2:0]             o_line2_sel,
    output logic                   o_gp_out_pin1,
    output logic                   o_gp_out_pin0,
    output logic                   o_gp_out_oe,
    // Beeper
    output logic [6:0]             o_beep_volume,
    output logic [7:0]             o_beep_freq
);

    // ****************************************************************
    // Write decode
    // ****************************************************************
    logic wr_hit;
    logic ld_ceil, ld_harm, ld_upper, ld_lower, ld_vol1, ld_vol2, ld_sw, ld_beep;
    logic [7:0] hi_byte;
    logic [8:0] sw_bits;

    assign wr_hit  = i_wr_stb && (i_wr_subaddr == bsc_pkg::SUBADDR_AUDIO_WR);
    assign hi_byte = i_wr_data[bsc_pkg::HI_MSB:bsc_pkg::HI_LSB];
    assign sw_bits = i_wr_data[bsc_pkg::SW_MSB:bsc_pkg::SW_LSB];

    // Unknown addresses on this subaddress are dropped
    always_comb begin
        ld_ceil  = 1'b0;
        ld_harm  = 1'b0;
        ld_upper = 1'b0;
        ld_lower = 1'b0;
        ld_vol1  = 1'b0;
        ld_vol2  = 1'b0;
        ld_sw    = 1'b0;
        ld_beep  = 1'b0;
        if (!wr_hit) begin
            ld_ceil = 1'b0;
        end else if (i_wr_regaddr == bsc_pkg::REG_BASS_CEILING) begin
            ld_ceil = 1'b1;
        end else if (i_wr_regaddr == bsc_pkg::REG_BASS_HARMONIC) begin
            ld_harm = 1'b1;
        end else if (i_wr_regaddr == bsc_pkg::REG_BASS_UPPER_CORN) begin
            ld_upper = 1'b1;
        end else if (i_wr_regaddr == bsc_pkg::REG_BASS_LOWER_CORN) begin
            ld_lower = 1'b1;
        end else if (i_wr_regaddr == bsc_pkg::REG_LINE_OUT1_VOL) begin
            ld_vol1 = 1'b1;
        end else if (i_wr_regaddr == bsc_pkg::REG_LINE_OUT2_VOL) begin
            ld_vol2 = 1'b1;
        end else if (i_wr_regaddr == bsc_pkg::REG_SWITCH_PINS) begin
            ld_sw = 1'b1;
        end else if (i_wr_regaddr == bsc_pkg::REG_BEEP_TONE) begin
            ld_beep = 1'b1;
        end
    end

    // ****************************************************************
    // Value decoders
    // ****************************************************************

    // Codes 0x01..0x7F and below 0xE0 are out of range and clamp
    function automatic logic signed [7:0] dec_ceiling(input logic [7:0] code);
        logic signed [7:0] s;
        s = $signed(code);
        if (s > bsc_pkg::CEIL_MAX_DBFS) begin
            return bsc_pkg::CEIL_MAX_DBFS;
        end else if (s < bsc_pkg::CEIL_MIN_DBFS) begin
            return bsc_pkg::CEIL_MIN_DBFS;
        end
        return s;
    endfunction

    // Corner code clamped to its legal range, then scaled to Hz
    function automatic logic [8:0] dec_corner(input logic [7:0] code, input logic [7:0] lo);
        logic [7:0] c;
        c = code;
        if (c < lo) begin
            c = lo;
        end else if (c > bsc_pkg::CORNER_CODE_MAX) begin
            c = bsc_pkg::CORNER_CODE_MAX;
        end
        return {1'b0, c} * bsc_pkg::HZ_PER_STEP;
    endfunction

    // Coarse step times eight plus fine step, relative to 0 dB
    function automatic logic signed [11:0] dec_gain(input logic [7:0] coarse, input logic [2:0] fine);
        logic signed [8:0] diff;
        diff = $signed({1'b0, coarse}) - bsc_pkg::VOL_ZERO_DB;
        return {diff, fine};
    endfunction

    function automatic logic [2:0] dec_dsp(input logic [8:0] s);
        case ({s[4], s[3], s[0]})
            3'b000:  return bsc_pkg::SRC_IN1;
            3'b010:  return bsc_pkg::SRC_MONO;
            3'b100:  return bsc_pkg::SRC_IN2;
            3'b110:  return bsc_pkg::SRC_IN3;
            3'b001:  return bsc_pkg::SRC_IN4;
            default: return bsc_pkg::SRC_MUTE; // Undefined codes mute, the safe choice
        endcase
    endfunction

    function automatic logic [2:0] dec_line1(input logic [8:0] s);
        case ({s[6], s[5], s[1]})
            3'b000:  return bsc_pkg::SRC_IN3;
            3'b010:  return bsc_pkg::SRC_IN2;
            3'b100:  return bsc_pkg::SRC_MONO;
            3'b110:  return bsc_pkg::SRC_DAC1;
            3'b001:  return bsc_pkg::SRC_DAC2;
            3'b011:  return bsc_pkg::SRC_IN1;
            3'b101:  return bsc_pkg::SRC_IN4;
            default: return bsc_pkg::SRC_MUTE;
        endcase
    endfunction

    function automatic logic [2:0] dec_line2(input logic [8:0] s);
        case ({s[8], s[7], s[2]})
            3'b000:  return bsc_pkg::SRC_DAC1;
            3'b010:  return bsc_pkg::SRC_IN1;
            3'b100:  return bsc_pkg::SRC_MONO;
            3'b110:  return bsc_pkg::SRC_MUTE;
            3'b001:  return bsc_pkg::SRC_DAC2;
            3'b011:  return bsc_pkg::SRC_IN2;
            3'b101:  return bsc_pkg::SRC_IN3;
            default: return bsc_pkg::SRC_IN4;
        endcase
    endfunction

    // ****************************************************************
    // Field storage, each decoded before it is stored
    // ****************************************************************
    logic [7:0] harm_clip;
    logic [7:0] beep_clip;
    assign harm_clip = (hi_byte > bsc_pkg::HARM_MAX) ? bsc_pkg::HARM_MAX : hi_byte;
    assign beep_clip = (hi_byte > bsc_pkg::BEEP_VOL_MAX) ? bsc_pkg::BEEP_VOL_MAX : hi_byte;

    bsc_field_reg #(.WIDTH(8), .RESET_VAL(bsc_pkg::CEIL_MAX_DBFS)) u_ceil (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_load (ld_ceil),
        .i_data (dec_ceiling(hi_byte)),
        .o_q    (o_bass_ceiling_dbfs)
    );

    bsc_field_reg #(.WIDTH(7), .RESET_VAL(7'h00)) u_harm (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_load (ld_harm),
        .i_data (harm_clip[6:0]),
        .o_q    (o_bass_harmonic_ratio)
    );

    bsc_field_reg #(.WIDTH(9), .RESET_VAL(bsc_pkg::UPPER_HZ_RST)) u_upper (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_load (ld_upper),
        .i_data (dec_corner(hi_byte, bsc_pkg::UPPER_CODE_MIN)),
        .o_q    (o_bass_upper_corner_hz)
    );

    // Also the top frequency of which harmonics are made
    bsc_field_reg #(.WIDTH(9), .RESET_VAL(bsc_pkg::LOWER_HZ_RST)) u_lower (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_load (ld_lower),
        .i_data (dec_corner(hi_byte, bsc_pkg::LOWER_CODE_MIN)),
        .o_q    (o_bass_lower_corner_hz)
    );

    // Gain and mute stored together so the mixer never sees them split
    bsc_field_reg #(.WIDTH(13), .RESET_VAL({1'b1, bsc_pkg::LINE_GAIN_RST})) u_vol1 (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_load (ld_vol1),
        .i_data ({hi_byte == bsc_pkg::VOL_MUTE_CODE,
                  dec_gain(hi_byte, i_wr_data[bsc_pkg::FINE_MSB:bsc_pkg::FINE_LSB])}),
        .o_q    ({o_line1_mute, o_line1_gain})
    );

    bsc_field_reg #(.WIDTH(13), .RESET_VAL({1'b1, bsc_pkg::LINE_GAIN_RST})) u_vol2 (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_load (ld_vol2),
        .i_data ({hi_byte == bsc_pkg::VOL_MUTE_CODE,
                  dec_gain(hi_byte, i_wr_data[bsc_pkg::FINE_MSB:bsc_pkg::FINE_LSB])}),
        .o_q    ({o_line2_mute, o_line2_gain})
    );

    // Pins and all three selectors move on the same edge
    bsc_field_reg #(.WIDTH(11),
                    .RESET_VAL({2'b00, bsc_pkg::SRC_IN1, bsc_pkg::SRC_IN3, bsc_pkg::SRC_DAC1})) u_sw (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_load (ld_sw),
        .i_data ({i_wr_data[bsc_pkg::PIN1_BIT], i_wr_data[bsc_pkg::PIN0_BIT],
                  dec_dsp(sw_bits), dec_line1(sw_bits), dec_line2(sw_bits)}),
        .o_q    ({o_gp_out_pin1, o_gp_out_pin0, o_dsp_in_sel, o_line1_sel, o_line2_sel})
    );

    bsc_field_reg #(.WIDTH(15), .RESET_VAL(15'h0000)) u_beep (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_load (ld_beep),
        .i_data ({beep_clip[6:0], i_wr_data[bsc_pkg::LO_MSB:bsc_pkg::LO_LSB]}),
        .o_q    ({o_beep_volume, o_beep_freq})
    );

    // ****************************************************************
    // First-write switch activation, pin drive and limiter
    // ****************************************************************
    localparam int unsigned REL_W = $clog2(RELEASE_DIV + 1);

    logic             active_d, active_q;
    logic             oe_d, oe_q;
    logic [5:0]       cut_d, cut_q;
    logic [REL_W-1:0] rel_d, rel_q;
    logic             rel_tick;

    // Release is slow on purpose: fast release would pump the bass
    assign rel_tick = (rel_q == REL_W'(RELEASE_DIV - 1));

    // Switch matrix inert until any audio write; a first switch write there wins
    always_comb begin
        active_d = active_q | wr_hit;
        oe_d     = ~i_mode_bit3;
        cut_d    = cut_q;
        rel_d    = rel_q;
        if (i_bass_level_stb && i_clip_dynamic) begin
            if (i_bass_level_dbfs > o_bass_ceiling_dbfs) begin
                rel_d = '0;
                if (cut_q != bsc_pkg::LIM_CUT_MAX) begin
                    cut_d = cut_q + 6'd1;
                end
            end else begin
                rel_d = rel_tick ? '0 : rel_q + REL_W'(1);
                if (rel_tick && (cut_q != 6'd0)) begin
                    cut_d = cut_q - 6'd1;
                end
            end
        end else if (!i_clip_dynamic) begin
            cut_d = '0;
            rel_d = '0;
        end
    end

    // State registers of this group
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            active_q <= 1'b0;
            oe_q     <= 1'b0;
            cut_q    <= '0;
            rel_q    <= '0;
        end else begin
            active_q <= active_d;
            oe_q     <= oe_d;
            cut_q    <= cut_d;
            rel_q    <= rel_d;
        end
    end

    assign o_switch_active    = active_q;
    assign o_gp_out_oe        = oe_q;
    assign o_bass_gain_cut_db = cut_q;

endmodule // bsc_ctrl_regs

`default_nettype wire

// ### tb/bsc_ctrl_regs_assertions.sv
`default_nettype none

// **********
// Register group checker
// **********
module bsc_ctrl_regs_assertions (
    // Clock, reset and write port
    input wire logic               i_mclk,
    input wire logic               i_rst,
    input wire logic               i_wr_stb,
    input wire logic [7:0]         i_wr_subaddr,
    input wire logic [15:0]        i_wr_regaddr,
    input wire logic [15:0]        i_wr_data,
    // Mode and level feedback
    input wire logic               i_mode_bit3,
    input wire logic               i_clip_dynamic,
    input wire logic               i_bass_level_stb,
    input wire logic signed [7:0]  i_bass_level_dbfs,
    // Watched outputs
    input wire logic signed [7:0]  o_bass_ceiling_dbfs,
    input wire logic [5:0]         o_bass_gain_cut_db,
    input wire logic [6:0]         o_bass_harmonic_ratio,
    input wire logic signed [11:0] o_line1_gain,
    input wire logic               o_switch_active,
    input wire logic [2:0]         o_line1_sel,
    input wire logic               o_gp_out_pin1,
    input wire logic               o_gp_out_pin0,
    input wire logic               o_gp_out_oe,
    input wire logic [7:0]         o_beep_freq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        hit;
    logic [15:0] data_q;

    // A write taken on the audio subaddress
    assign hit = i_wr_stb && (i_wr_subaddr == 8'h12);

    // Last word, read one cycle after the write
    always_ff @(posedge i_mclk) data_q <= i_wr_data;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // Activation and refusal
    property p_activate; hit |=> o_switch_active; endproperty
    a_activate: assert property (p_activate) else $error("switch matrix not active");
    property p_ignore; !hit && !o_switch_active |=> !o_switch_active; endproperty
    a_ignore: assert property (p_ignore) else $error("switch matrix active without write");

    // Field decoding, one cycle after the write
    property p_harm; hit && i_wr_regaddr == 16'h006A && !i_wr_data[15] |=> o_bass_harmonic_ratio == data_q[14:8];
    endproperty
    a_harm: assert property (p_harm) else $error("harmonic ratio wrong");
    property p_beep; hit && i_wr_regaddr == 16'h0014 |=> o_beep_freq == data_q[7:0]; endproperty
    a_beep: assert property (p_beep) else $error("beep frequency wrong");
    property p_pins; hit && i_wr_regaddr == 16'h0013 |=> {o_gp_out_pin1, o_gp_out_pin0} == data_q[15:14];
    endproperty
    a_pins: assert property (p_pins) else $error("pin levels wrong");
    property p_gain;
        hit && i_wr_regaddr == 16'h0007 && i_wr_data[15:8] != 8'h00
            |=> o_line1_gain == 12'({4'h0, data_q[15:8]} * 8 + data_q[7:5] - 920);
    endproperty
    a_gain: assert property (p_gain) else $error("line 1 gain wrong");

    // Pin enable follows the inverted mode bit one cycle late
    property p_oe; !$past(i_rst) |-> o_gp_out_oe == !$past(i_mode_bit3); endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong");

    // Limiter raises its cut on an over-ceiling sample
    property p_cut;
        i_bass_level_stb && i_clip_dynamic && i_bass_level_dbfs > o_bass_ceiling_dbfs && o_bass_gain_cut_db < 6'h20
            |=> o_bass_gain_cut_db == $past(o_bass_gain_cut_db) + 6'h01;
    endproperty
    a_cut: assert property (p_cut) else $error("limiter cut not raised");

    // Without a write the fields hold whole
    property p_hold; !hit |=> $stable(o_beep_freq) && $stable(o_line1_sel) && $stable(o_bass_harmonic_ratio);
    endproperty
    a_hold: assert property (p_hold) else $error("field changed without write");

    // Main scenarios reached
    c_cut: cover property (o_bass_gain_cut_db == 6'h03);
    c_mute: cover property (o_line1_sel == 3'h7);
    c_pins: cover property (o_gp_out_pin1 && !o_gp_out_pin0 && o_gp_out_oe);
endmodule // bsc_ctrl_regs_assertions

bind bsc_ctrl_regs bsc_ctrl_regs_assertions chk_u (
    .i_mclk, .i_rst, .i_wr_stb, .i_wr_subaddr, .i_wr_regaddr, .i_wr_data, .i_mode_bit3, .i_clip_dynamic,
    .i_bass_level_stb, .i_bass_level_dbfs, .o_bass_ceiling_dbfs, .o_bass_gain_cut_db, .o_bass_harmonic_ratio,
    .o_line1_gain, .o_switch_active, .o_line1_sel, .o_gp_out_pin1, .o_gp_out_pin0, .o_gp_out_oe, .o_beep_freq
);

`default_nettype wire

// ### tb/bsc_host_model.sv
`default_nettype none

// **********
// Host controller issuing register writes
// **********
module bsc_host_model (
    // Clock
    input  wire logic       i_mclk,
    // Write port
    output var logic        o_wr_stb,
    output var logic [7:0]  o_wr_subaddr,
    output var logic [15:0] o_wr_regaddr,
    output var logic [15:0] o_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at start
    initial begin
        o_wr_stb = 1'b0;
        o_wr_subaddr = 8'h00;
        o_wr_regaddr = 16'h0000;
        o_wr_data = 16'h0000;
    end

    // One write; strobe stays up for back-to-back writes
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] s = 8'h12);
        logic [15:0] v;
        v = d;
        if (a == 16'h0007 || a == 16'h0040) v[4:0] = 5'h01;
        else if (a == 16'h0013) v[4:0] = 5'h00;
        else if (a[15:4] == 12'h006) v[7:0] = 8'h00;
        @(negedge i_mclk);
        o_wr_stb = 1'b1;
        o_wr_subaddr = s;
        o_wr_regaddr = a;
        o_wr_data = v;
    endtask

    // Release; stale lines go to their inverse
    task automatic idle;
        @(negedge i_mclk);
        o_wr_stb = 1'b0;
        o_wr_subaddr = ~o_wr_subaddr;
        o_wr_regaddr = ~o_wr_regaddr;
        o_wr_data = ~o_wr_data;
    endtask
endmodule // bsc_host_model

`default_nettype wire

// ### tb/tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // **********
    // Signals and instances
    // **********
    localparam int unsigned DIV = 4;
    logic               mclk, rst, stb, mode3, clip, lvl_stb, m1, m2, act, p1, p0, oe;
    logic [7:0]         sub, bfreq;
    logic [15:0]        ra, wd;
    logic signed [7:0]  lvl, ceil;
    logic [5:0]         cut;
    logic [6:0]         harm, bvol;
    logic [8:0]         up_hz, lo_hz;
    logic signed [11:0] g1, g2;
    logic [2:0]         dsel, l1sel, l2sel;
    logic [2:0]         l1_tab [8] = '{2, 1, 4, 5, 6, 0, 3, 7};
    logic [2:0]         l2_tab [8] = '{5, 0, 4, 7, 6, 1, 2, 3};
    logic [2:0]         dsp_tab [8] = '{0, 4, 1, 2, 3, 7, 7, 7};
    int                 err_total = 0;
    int                 comparisons = 0;

    bsc_host_model host_u (.i_mclk(mclk), .o_wr_stb(stb), .o_wr_subaddr(sub), .o_wr_regaddr(ra), .o_wr_data(wd));
    bsc_ctrl_regs #(.RELEASE_DIV(DIV)) dut_u (
        .i_mclk(mclk), .i_rst(rst), .i_wr_stb(stb), .i_wr_subaddr(sub), .i_wr_regaddr(ra), .i_wr_data(wd),
        .i_mode_bit3(mode3), .i_clip_dynamic(clip), .i_bass_level_stb(lvl_stb), .i_bass_level_dbfs(lvl),
        .o_bass_ceiling_dbfs(ceil), .o_bass_gain_cut_db(cut), .o_bass_harmonic_ratio(harm),
        .o_bass_upper_corner_hz(up_hz), .o_bass_lower_corner_hz(lo_hz), .o_line1_gain(g1), .o_line1_mute(m1),
        .o_line2_gain(g2), .o_line2_mute(m2), .o_switch_active(act), .o_dsp_in_sel(dsel), .o_line1_sel(l1sel),
        .o_line2_sel(l2sel), .o_gp_out_pin1(p1), .o_gp_out_pin0(p0), .o_gp_out_oe(oe), .o_beep_volume(bvol),
        .o_beep_freq(bfreq)
    );

    // Clock
    always #12.5 mclk = ~mclk;

    // **********
    // Shared tasks
    // **********
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run;
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic do_reset;
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
    endtask

    // Level samples, one per cycle
    task automatic feed(input int n, input logic signed [7:0] v);
        lvl = v;
        repeat (n) begin
            @(negedge mclk);
            lvl_stb = 1'b1;
        end
        @(negedge mclk);
        lvl_stb = 1'b0;
    endtask

    // **********
    // Scenarios
    // **********
    task automatic t_reset_vals;
        chk("active", 0, act);
        chk("selectors", {3'd0, 3'd2, 3'd5}, {dsel, l1sel, l2sel});
        chk("mutes", 2'b11, {m1, m2});
        chk("ceiling", 0, ceil);
        chk("harmonics", 0, harm);
        chk("beep vol", 0, bvol);
    endtask

    // Wrong subaddress, then unknown address, then a fresh start by a switch write
    task automatic t_refuse;
        host_u.wr(16'h0013, 16'hFFE0, 8'h13);
        host_u.idle();
        chk("active", 0, act);
        host_u.wr(16'h0050, 16'hFFE0);
        host_u.idle();
        chk("active", 1, act);
        chk("selectors", {3'd0, 3'd2, 3'd5}, {dsel, l1sel, l2sel});
        do_reset();
        host_u.wr(16'h0013, 16'hFFE0);
        host_u.idle();
        chk("selectors", {3'd7, 3'd7, 3'd3}, {dsel, l1sel, l2sel});
    endtask

    // Every code of the three selectors at once, fields are disjoint
    task automatic t_switch;
        logic [2:0] c;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            host_u.wr(16'h0013, {c[0], ~c[0], {3{c[1:0]}}, {3{c[2]}}, 5'h00});
            host_u.idle();
            chk("dsp sel", dsp_tab[k], dsel);
            chk("line1 sel", l1_tab[k], l1sel);
            chk("line2 sel", l2_tab[k], l2sel);
            chk("pins", {c[0], ~c[0]}, {p1, p0});
        end
    endtask

    task automatic t_mode;
        chk("pin enable", 1, oe);
        mode3 = 1'b1;
        @(negedge mclk);
        chk("pin enable", 0, oe);
        mode3 = 1'b0;
        @(negedge mclk);
    endtask

    // Both line volumes written back to back
    task automatic t_vol;
        logic [7:0] v [4] = '{8'h7F, 8'h73, 8'h01, 8'h00};
        logic [2:0] f [4] = '{3'd7, 3'd0, 3'd1, 3'd0};
        for (int k = 0; k < 4; k++) begin
            host_u.wr(16'h0007, {v[k], f[k], 5'h00});
            host_u.wr(16'h0040, {v[k], f[k], 5'h00});
            host_u.idle();
            chk("mutes", {2{v[k] == 8'h00}}, {m1, m2});
            if (v[k] != 8'h00) begin
                chk("line1 gain", 16'((int'(v[k]) - 115) * 8 + f[k]), g1);
                chk("line2 gain", 16'((int'(v[k]) - 115) * 8 + f[k]), g2);
            end
        end
    endtask

    task automatic t_bass;
        int cl [2] = '{-1, -32};
        int hr [2] = '{63, 127};
        int up [2] = '{30, 5};
        int lo [2] = '{10, 3};
        for (int k = 0; k < 2; k++) begin
            host_u.wr(16'h0069, {8'(cl[k]), 8'h00});
            host_u.wr(16'h006A, {8'(hr[k]), 8'h00});
            host_u.wr(16'h006B, {8'(up[k]), 8'h00});
            host_u.wr(16'h006C, {8'(lo[k]), 8'h00});
            host_u.idle();
            chk("ceiling", 16'(cl[k]), ceil);
            chk("harmonics", 16'(hr[k]), harm);
            chk("upper hz", 16'(up[k] * 10), up_hz);
            chk("lower hz", 16'(lo[k] * 10), lo_hz);
        end
    endtask

    task automatic t_beep;
        logic [15:0] w [3] = '{16'h7F40, 16'h00FF, 16'h2001};
        for (int k = 0; k < 3; k++) begin
            host_u.wr(16'h0014, w[k]);
            host_u.idle();
            chk("beep", w[k], {1'b0, bvol, bfreq});
        end
    endtask

    // Ceiling -3 dBFS: three loud samples, then release after DIV quiet ones
    task automatic t_limit;
        host_u.wr(16'h0069, 16'hFD00);
        host_u.idle();
        clip = 1'b1;
        feed(3, 8'sh00);
        chk("cut", 3, cut);
        feed(DIV - 1, -8'sd10);
        chk("cut", 3, cut);
        feed(1, -8'sd10);
        chk("cut", 2, cut);
        clip = 1'b0;
        repeat (2) @(negedge mclk);
        chk("cut", 0, cut);
    endtask

    // Main sequence
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        mode3 = 1'b0;
        clip = 1'b0;
        lvl_stb = 1'b0;
        lvl = 8'sh00;
        do_reset();
        t_reset_vals();
        t_refuse();
        t_switch();
        t_mode();
        t_vol();
        t_bass();
        t_beep();
        t_limit();
        complete_run();
    end

    // Watchdog, far past the 70 or so cycles needed
    initial begin
        #(25 * 8000);
        err_total++;
        complete_run();
    end
endmodule // tb

`default_nettype wire
